// ==== rtl/put_pkg.sv ====
// ============================================================
// shared constants and types of the prescaled underflow timer
package put_pkg;

    // ============================================================
    // register byte addresses
    localparam logic [7:0] ADDR_PRESCALE = 8'hd2;
    localparam logic [7:0] ADDR_COUNT = 8'hd3;
    localparam logic [7:0] ADDR_CTRL = 8'hd4;

    // ============================================================
    // control/status field positions
    localparam int unsigned BIT_FLAG = 7;
    localparam int unsigned BIT_IRQEN = 6;
    localparam int unsigned BIT_RSV_SET = 5;
    localparam int unsigned BIT_RSV_CLR = 4;
    localparam int unsigned BIT_RUN = 3;
    localparam int unsigned SEL_LSB = 0;

    // ============================================================
    // reset, preset and reload values
    localparam logic [7:0] COUNT_RESET = 8'hff;
    localparam logic [7:0] COUNT_RELOAD = 8'hff;
    localparam logic [6:0] CTRL_RESET = 7'h00;
    localparam logic [6:0] PRESCALE_PRESET = 7'h7f;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ============================================================
    // cycle counts: internal clock divided by twelve
    localparam logic [3:0] DIV_LAST = 4'hb;

    // ============================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;   // byte address
        logic [7:0] wrData; // write data
        logic wrStb;        // one-cycle write strobe
        logic rdStb;        // one-cycle read strobe
    } put_bus_req_s;

    typedef struct packed {
        logic run;          // prescale_run
        logic [2:0] sel;    // prescale_select
    } put_psc_cfg_s;

    // ============================================================
    // true when the low sel bits of the prescaler are all zero,
    // so code n fires once every two to the n prescaler steps
    function automatic logic tapHit(input logic [6:0] value,
                                    input logic [2:0] sel);
        logic [7:0] mask;
        mask = (8'h01 << sel) - 8'h01;
        return (value & mask[6:0]) == 7'h00;
    endfunction

endpackage

// ==== rtl/put_div12.sv ====
`timescale 1ns/10ps
// ============================================================
// divide-by-twelve enable: one pulse every twelve core cycles
module put_div12 (
    input wire logic core_clk,
    input wire logic rst_b,
    output logic tick
);
    logic [3:0] cnt_r; // position in the twelve-cycle frame
    logic [3:0] cnt_nxt;
    logic tick_r;      // registered pulse, no derived clock
    logic tick_nxt;

    // next frame position and pulse
    always_comb begin
        if (cnt_r == put_pkg::DIV_LAST) begin
            cnt_nxt = 4'h0;
            tick_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 4'h1;
            tick_nxt = 1'b0;
        end
    end

    // registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 4'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            tick_r <= tick_nxt;
        end
    end

    assign tick = tick_r;

    a_tick_period: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        tick |-> ##12 tick)
        else $error("divider pulse not twelve cycles apart");
    a_tick_gap: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        tick |=> !tick [*8])
        else $error("divider pulse repeated too soon");
endmodule

// ==== rtl/put_prescaler.sv ====
`timescale 1ns/10ps
// ============================================================
// seven-bit down prescaler with eight power-of-two taps
module put_prescaler (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire put_pkg::put_psc_cfg_s cfg,
    input wire logic wrEn,
    input wire logic [6:0] wrData,
    output logic [6:0] value,
    output logic tap
);
    logic [6:0] psc_r; // prescaler state
    logic [6:0] psc_nxt;

    // tap fires on a step whose low bits are zero
    assign tap = tick && cfg.run &&
                 put_pkg::tapHit(psc_r, cfg.sel);

    // next prescaler value
    always_comb begin
        psc_nxt = psc_r;
        if (!cfg.run) begin
            psc_nxt = put_pkg::PRESCALE_PRESET;
        end else if (wrEn) begin
            psc_nxt = wrData; // direct load only while running
        end else if (tick) begin
            if (psc_r == 7'h00) begin
                psc_nxt = put_pkg::PRESCALE_PRESET;
            end else begin
                psc_nxt = psc_r - 7'h01;
            end
        end
    end

    // registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            psc_r <= put_pkg::PRESCALE_PRESET;
        end else begin
            psc_r <= psc_nxt;
        end
    end

    assign value = psc_r;

    a_preset_hold: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !cfg.run |=> psc_r == 7'h7f)
        else $error("prescaler not held at preset");
    a_psc_reload: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        cfg.run && tick && !wrEn && psc_r == 7'h00 |=> psc_r == 7'h7f)
        else $error("prescaler did not reload");
    a_tap_slowest: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        tap && cfg.sel == 3'h7 |-> psc_r == 7'h00)
        else $error("slowest tap fired off zero");
endmodule

// ==== rtl/put_timer.sv ====
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps
// What this block does
// - flag set when counter wraps zero to ones
// - request only while enable and flag high
// - run low presets prescaler, freezes counter
// - run high lets prescaler and counter count
// - select code n divides by two^n
// - reset gives counter ones, control zero
// - prescaler steps at clock/12, reloads 7Fh
// - counter steps per tap, reloads all ones
// - writing zero count or flag one sets flag
// - counter write beats decrement, no flag
module put_timer (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire put_pkg::put_bus_req_s busReq,
    output logic [7:0] rdData,
    output logic irq
);
    // ============================================================
    // declarations
    logic [7:0] cnt_r;   // count_value_reg
    logic [7:0] cnt_nxt;
    logic flag_r;        // underflow_flag
    logic flag_nxt;
    logic [6:0] ctrl_r;  // control bits 6:0 as stored
    logic [6:0] ctrl_nxt;
    logic [7:0] rd_r;    // read data, valid one cycle
    logic [7:0] rd_nxt;
    logic irq_r;         // registered interrupt request
    logic irq_nxt;
    logic cntWr;         // write to the counter
    logic ctrlWr;        // write to control/status
    logic pscWr;         // write to the prescaler
    logic hwUnder;       // counter wrapped this cycle
    logic swSet;         // software forced the flag
    logic divTick;       // clock/12 enable
    logic tap;           // counter step enable
    logic [6:0] pscValue; // prescaler state for reads
    put_pkg::put_psc_cfg_s pscCfg;

    // ============================================================
    // address decode
    assign cntWr = busReq.wrStb && busReq.addr == put_pkg::ADDR_COUNT;
    assign ctrlWr = busReq.wrStb && busReq.addr == put_pkg::ADDR_CTRL;
    assign pscWr = busReq.wrStb &&
                   busReq.addr == put_pkg::ADDR_PRESCALE;

    // prescaler configuration taken from stored control bits;
    // one assignment keeps the carrier a single-driver variable
    assign pscCfg = '{run: ctrl_r[put_pkg::BIT_RUN],
                      sel: ctrl_r[put_pkg::SEL_LSB +: 3]};

    // ============================================================
    // rate generation
    // twelve-cycle enable; nothing here makes a derived clock,
    // so every flop stays on core_clk
    put_div12 u_div (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tick(divTick)
    );

    // prescaler and its tap select
    put_prescaler u_psc (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tick(divTick),
        .cfg(pscCfg),
        .wrEn(pscWr),
        .wrData(busReq.wrData[6:0]),
        .value(pscValue),
        .tap(tap)
    );

    // ============================================================
    // counter next value
    // a software write wins over the step, so the step of that
    // cycle is lost; this matches the counter being reloaded
    always_comb begin
        cnt_nxt = cnt_r;
        hwUnder = 1'b0;
        if (cntWr) begin
            // write wins, no underflow from the step
            cnt_nxt = busReq.wrData;
        end else if (tap) begin
            // tap is already gated by the run bit
            if (cnt_r == 8'h00) begin
                cnt_nxt = put_pkg::COUNT_RELOAD;
                hwUnder = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 8'h01;
            end
        end
    end

    // ============================================================
    // flag, control and request next values
    always_comb begin
        // software forcing paths
        swSet = (cntWr && busReq.wrData == 8'h00) ||
                (ctrlWr && busReq.wrData[put_pkg::BIT_FLAG]);
        flag_nxt = flag_r;
        if (hwUnder || swSet) begin
            // a set in the clearing cycle is kept
            flag_nxt = 1'b1;
        end else if (ctrlWr) begin
            // only a written zero clears it
            flag_nxt = 1'b0;
        end
        // reserved bits are stored as written and read back
        ctrl_nxt = ctrl_r;
        if (ctrlWr) begin
            ctrl_nxt = busReq.wrData[6:0];
        end
        // request follows the same edge as flag and enable
        irq_nxt = flag_nxt &&
                  ctrl_nxt[put_pkg::BIT_IRQEN];
    end

    // ============================================================
    // read mux
    // read data stand only in the cycle after the strobe;
    // idle cycles and unmapped addresses read zero
    always_comb begin
        rd_nxt = put_pkg::READ_IDLE;
        if (busReq.rdStb) begin
            case (busReq.addr)
                put_pkg::ADDR_PRESCALE: begin
                    // top bit unused, reads zero
                    rd_nxt = {1'b0, pscValue};
                end
                put_pkg::ADDR_COUNT: begin
                    // value before any step of this cycle
                    rd_nxt = cnt_r;
                end
                put_pkg::ADDR_CTRL: begin
                    rd_nxt = {flag_r, ctrl_r};
                end
                default: begin
                    rd_nxt = put_pkg::READ_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // registers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= put_pkg::COUNT_RESET;
            flag_r <= 1'b0;
            ctrl_r <= put_pkg::CTRL_RESET;
            rd_r <= put_pkg::READ_IDLE;
            irq_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
            ctrl_r <= ctrl_nxt;
            rd_r <= rd_nxt;
            irq_r <= irq_nxt;
        end
    end

    // outputs straight from flops
    assign rdData = rd_r;
    assign irq = irq_r;

    // ============================================================
    // checking helpers
    // marks the first edge after reset release
    logic firstEdge_r;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            firstEdge_r <= 1'b1;
        end else begin
            firstEdge_r <= 1'b0;
        end
    end

    // ============================================================
    // assertions
    a_wrap_sets_flag: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        tap && !cntWr && cnt_r == 8'h00 |=>
            flag_r && cnt_r == 8'hff)
        else $error("wrap did not set flag or reload");

    a_flag_sticky: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        flag_r && !ctrlWr |=> flag_r)
        else $error("flag cleared without a write");

    a_irq_gating: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        irq_r == (flag_r && ctrl_r[6]))
        else $error("request not enable and flag");

    a_counter_frozen: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !ctrl_r[3] && !cntWr |=> cnt_r == $past(cnt_r))
        else $error("counter moved while stopped");

    a_count_step: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        tap && !cntWr && cnt_r != 8'h00 |=>
            cnt_r == $past(cnt_r) - 8'h01)
        else $error("counter did not step by one");

    a_tap_rate: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        ctrl_r[3] && ctrl_r[2:0] == 3'h0 && divTick && !pscWr
            |-> tap)
        else $error("divide by one missed a step");

    a_reset_values: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        firstEdge_r |-> cnt_r == 8'hff && ctrl_r == 7'h00 &&
            !flag_r && !irq_r && pscValue == 7'h7f)
        else $error("wrong values after reset");

    a_zero_write_set: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        cntWr && busReq.wrData == 8'h00 |=> flag_r)
        else $error("zero write did not set flag");

    a_flag_write_set: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        ctrlWr && busReq.wrData[7] |=> flag_r)
        else $error("flag write did not set flag");

    a_write_wins: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        cntWr && tap && busReq.wrData != 8'h00 && !flag_r |=>
            !flag_r && cnt_r == $past(busReq.wrData))
        else $error("step beat a counter write");

    a_read_count: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        busReq.rdStb && busReq.addr == put_pkg::ADDR_COUNT |=>
            rdData == $past(cnt_r))
        else $error("counter read wrong");

    a_read_idle: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        !busReq.rdStb |=> rdData == 8'h00)
        else $error("read data outside its cycle");

    // register port: stores, clears and read-back paths
    a_flag_clear: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        ctrlWr && !busReq.wrData[7] && !hwUnder |=> !flag_r)
        else $error("flag not cleared by a zero write");

    a_write_lands: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        cntWr |=> cnt_r == $past(busReq.wrData))
        else $error("counter write not stored");

    a_ctrl_store: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        ctrlWr |=> ctrl_r == $past(busReq.wrData[6:0]))
        else $error("control bits not stored as written");

    a_run_start: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        ctrlWr && busReq.wrData[3] && !ctrl_r[3] |=>
            pscValue == 7'h7f)
        else $error("prescaler not preset at start");

    a_read_ctrl: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        busReq.rdStb && busReq.addr == put_pkg::ADDR_CTRL |=>
            rdData == {$past(flag_r), $past(ctrl_r)})
        else $error("control read wrong");

    a_read_prescale: assert property (
        @(posedge core_clk) disable iff (!rst_b)
        busReq.rdStb && busReq.addr == put_pkg::ADDR_PRESCALE |=>
            rdData == {1'b0, $past(pscValue)})
        else $error("prescaler read wrong");

    // ============================================================
    // covers
    c_underflow: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        hwUnder ##1 irq_r);
    c_collision: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        cntWr && tap && cnt_r == 8'h00);
    c_slow_tap: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        tap && ctrl_r[2:0] == 3'h7);
    c_flag_clear: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        flag_r ##1 !flag_r);
    c_zero_write: cover property (
        @(posedge core_clk) disable iff (!rst_b)
        cntWr && busReq.wrData == 8'h00);
endmodule

// ==== testbench/prescaled_underflow_timer_tb.sv ====
`timescale 1ns/10ps
// ============================================================
// self-checking bench: register port driven by hand, one task per case
module prescaled_underflow_timer_tb;

    logic core_clk; // 100 MHz core clock
    logic rst_b; // async reset, active low
    put_pkg::put_bus_req_s busReq; // register port request
    logic [7:0] rdData; // read data, one cycle after the strobe
    logic irq; // interrupt request level
    int fails = 0; // mismatches seen
    int totalChecks = 0; // comparisons made

    put_timer uut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .busReq(busReq),
        .rdData(rdData),
        .irq(irq)
    );

    // ============================================================
    // clock and watchdog
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // the whole run needs well under 20000 cycles
    initial begin
        repeat (50000) @(posedge core_clk);
        fails++;
        $display("[ERR] %0t run hung", $time);
        end_of_test();
    end

    // ============================================================
    // shared tasks
    task automatic end_of_test();
        if (fails == 0 && totalChecks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one-cycle write; an idle edge follows so strobes never abut
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        busReq.addr <= a;
        busReq.wrData <= d;
        busReq.wrStb <= 1'b1;
        @(posedge core_clk);
        busReq.wrStb <= 1'b0;
        @(posedge core_clk);
    endtask

    // data are only valid in the cycle after the strobe
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp,
                            input string what);
        logic [7:0] d;
        busReq.addr <= a;
        busReq.rdStb <= 1'b1;
        @(posedge core_clk);
        busReq.rdStb <= 1'b0;
        #1;
        d = rdData;
        check(d, exp, what);
        @(posedge core_clk);
    endtask

    // back-to-back reads until the value moves; gives the moment seen
    task automatic watch(input logic [7:0] a, output logic [7:0] oldV,
                         output logic [7:0] newV, output longint t);
        int n;
        busReq.addr <= a;
        busReq.rdStb <= 1'b1;
        @(posedge core_clk);
        @(posedge core_clk);
        #1;
        oldV = rdData;
        newV = oldV;
        n = 0;
        while (newV === oldV && n < 4000) begin
            @(posedge core_clk);
            #1;
            newV = rdData;
            n++;
        end
        busReq.rdStb <= 1'b0;
        t = $time;
        check({7'h00, n < 4000}, 8'h01, "value never moved");
    endtask

    // ============================================================
    // scenarios
    task automatic t_reset();
        check({7'h00, irq}, 8'h00, "irq after reset");
        rd_check(put_pkg::ADDR_COUNT, 8'hff, "count reset");
        rd_check(put_pkg::ADDR_CTRL, 8'h00, "ctrl reset");
        rd_check(put_pkg::ADDR_PRESCALE, 8'h7f, "presc reset");
        rd_check(8'hd5, 8'h00, "unmapped read");
        #1;
        check(rdData, 8'h00, "read data lingered");
    endtask

    // stopped timer: counter writable but frozen, prescaler pinned
    task automatic t_frozen();
        wr(put_pkg::ADDR_CTRL, 8'h20);
        wr(put_pkg::ADDR_COUNT, 8'h40);
        wr(put_pkg::ADDR_PRESCALE, 8'h10);
        repeat (60) @(posedge core_clk);
        rd_check(put_pkg::ADDR_COUNT, 8'h40, "count frozen");
        rd_check(put_pkg::ADDR_PRESCALE, 8'h7f, "presc held");
        rd_check(put_pkg::ADDR_CTRL, 8'h20, "ctrl readback");
    endtask

    // three taps of twelve cycles take 02 through 00 to ff
    task automatic t_underflow();
        int n;
        wr(put_pkg::ADDR_COUNT, 8'h02);
        wr(put_pkg::ADDR_CTRL, 8'h68);
        n = 0;
        while (irq !== 1'b1 && n < 100) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        check({7'h00, n >= 24 && n <= 35}, 8'h01, "wrap time");
        rd_check(put_pkg::ADDR_COUNT, 8'hff, "reload");
        rd_check(put_pkg::ADDR_CTRL, 8'he8, "flag set");
    endtask

    // flag stays until written low; enable gates the request
    task automatic t_sticky();
        repeat (40) @(posedge core_clk);
        #1;
        check({7'h00, irq}, 8'h01, "flag dropped");
        wr(put_pkg::ADDR_CTRL, 8'h28);
        rd_check(put_pkg::ADDR_CTRL, 8'h28, "flag clear");
        check({7'h00, irq}, 8'h00, "irq no flag");
        wr(put_pkg::ADDR_CTRL, 8'ha8);
        rd_check(put_pkg::ADDR_CTRL, 8'ha8, "flag by write");
        check({7'h00, irq}, 8'h00, "irq disabled");
        wr(put_pkg::ADDR_CTRL, 8'he8);
        #1;
        check({7'h00, irq}, 8'h01, "irq enabled");
        wr(put_pkg::ADDR_CTRL, 8'h20);
    endtask

    task automatic t_zero_write();
        wr(put_pkg::ADDR_COUNT, 8'h00);
        rd_check(put_pkg::ADDR_CTRL, 8'ha0, "zero write");
        wr(put_pkg::ADDR_CTRL, 8'h20);
    endtask

    // a count write landing on a wrap edge must win, with no flag
    task automatic t_write_wins();
        logic [7:0] o;
        logic [7:0] v;
        longint t;
        wr(put_pkg::ADDR_COUNT, 8'h30);
        wr(put_pkg::ADDR_CTRL, 8'h28);
        watch(put_pkg::ADDR_COUNT, o, v, t);
        // next tap edge is eleven edges after this point
        wr(put_pkg::ADDR_COUNT, 8'h00);
        @(posedge core_clk);
        wr(put_pkg::ADDR_CTRL, 8'h28);
        repeat (5) @(posedge core_clk);
        wr(put_pkg::ADDR_COUNT, 8'h05);
        rd_check(put_pkg::ADDR_COUNT, 8'h05, "write lost");
        rd_check(put_pkg::ADDR_CTRL, 8'h28, "flag on write");
    endtask

    // direct prescaler load, then 01, 00, 7f at twelve-cycle steps
    task automatic t_reload();
        logic [7:0] o;
        logic [7:0] v;
        longint t1;
        longint t2;
        watch(put_pkg::ADDR_COUNT, o, v, t1);
        wr(put_pkg::ADDR_PRESCALE, 8'h01);
        watch(put_pkg::ADDR_PRESCALE, o, v, t1);
        check(o, 8'h01, "presc load");
        check(v, 8'h00, "presc step");
        @(posedge core_clk);
        watch(put_pkg::ADDR_PRESCALE, o, v, t2);
        check(v, 8'h7f, "presc reload");
        check({7'h00, t2 - t1 == 120}, 8'h01, "clock/12");
    endtask

    // every select code: tap spacing of 12 times two to the n
    task automatic t_select();
        logic [7:0] o;
        logic [7:0] v;
        longint t1;
        longint t2;
        for (int n = 0; n < 8; n++) begin
            wr(put_pkg::ADDR_CTRL, 8'h28 | 8'(n));
            watch(put_pkg::ADDR_COUNT, o, v, t1);
            @(posedge core_clk);
            watch(put_pkg::ADDR_COUNT, o, v, t1);
            @(posedge core_clk);
            watch(put_pkg::ADDR_COUNT, o, v, t2);
            check({7'h00, t2 - t1 == longint'(120 << n)}, 8'h01,
                  "tap spacing");
            check(v, 8'(o - 8'h01), "count step");
        end
    endtask

    // ============================================================
    // main sequence
    initial begin
        busReq = '0;
        rst_b = 1'b0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_frozen();
        t_underflow();
        t_sticky();
        t_zero_write();
        t_write_wins();
        t_reload();
        t_select();
        end_of_test();
    end

endmodule
